/* rtl/spi_cmd_pkg.sv */
package spi_cmd_pkg;

	// ---------------------------------------------------------------
	// Datagram layout
	// ---------------------------------------------------------------
	localparam int         FRAME_BITS    = 40;
	localparam int         DATA_BITS     = 32;
	localparam int         ADDR_BITS     = 8;
	localparam int         RW_POS        = 39;
	localparam int         ADDR_MSB      = 38;
	localparam int         ADDR_LSB      = 32;
	localparam int         CNT_W         = 6;
	localparam logic [5:0] CNT_ADDR_DONE = 6'h08;
	localparam logic [5:0] CNT_FRAME     = 6'h28;
	localparam logic [5:0] CNT_MAX       = 6'h3f;
	localparam logic [7:0] WRITE_FLAG    = 8'h80;

	// ---------------------------------------------------------------
	// Register file of the device end
	// ---------------------------------------------------------------
	localparam int          REG_COUNT = 8;
	localparam int          REG_IDX_W = 3;
	localparam logic [6:0]  WOC_ADDR  = 7'h01;
	localparam logic [31:0] REG_RESET = 32'h00000000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ         = 40000;
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int FILT_NS         = 20;
	localparam int FILT_CYCLES     =
		(FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCK_DIV_EXT     = 6;
	localparam int SCK_MAX_INT_KHZ = 3500;
	localparam int SAFETY_PCT      = 10;
	localparam int HALF_FAST       = SCK_DIV_EXT / 2;
	localparam int HALF_SLOW       =
		(CLK_KHZ * (100 + SAFETY_PCT) + 2 * SCK_MAX_INT_KHZ * 100 - 1)
		/ (2 * SCK_MAX_INT_KHZ * 100);
	localparam int GAP_CYCLES      = 8;
	localparam int HCNT_W          = 4;

endpackage

/* rtl/spi_link_if.sv */
`timescale 1ns/1ps
interface spi_link_if;
	// Link wires
	logic sck;
	logic chip_select_n;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	// Line level with a pull-up when nobody drives
	wire  serial_out_line = serial_out_oe ? serial_out : 1'b1;

	modport device (
		input  sck,
		input  chip_select_n,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output sck,
		output chip_select_n,
		output serial_in,
		input  serial_out_line
	);
endinterface

/* rtl/glitch_filter.sv */
`timescale 1ns/1ps
module glitch_filter #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Raw level and filtered level
	input  wire logic async_in,
	output logic      filt_out
);

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [1:0] cnt;
		logic       lvl;
	} flt_t;

	flt_t f_r;
	flt_t f_nxt;

	// Accept a new level only after it stays for the filter time
	always_comb begin
		f_nxt = f_r;
		if (ce) begin
			f_nxt.s1 = async_in;
			f_nxt.s2 = f_r.s1;
			if (f_r.s2 == f_r.lvl) begin
				f_nxt.cnt = 2'h0;
			end else if (f_r.cnt == 2'(spi_cmd_pkg::FILT_CYCLES)) begin
				f_nxt.lvl = f_r.s2;
				f_nxt.cnt = 2'h0;
			end else begin
				f_nxt.cnt = f_r.cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			f_r <= '{s1: INIT, s2: INIT, cnt: 2'h0, lvl: INIT};
		end else begin
			f_r <= f_nxt;
		end
	end

	assign filt_out = f_r.lvl;

endmodule

/* rtl/spi_cmd_device.sv */
// Functional notes
// - Take part only while chip select low
// - Sample rising clock, drive after falling
// - Shift datagrams most significant bit first
// - Master gives at least 40 clocks
// - No daisy chain, own chip select
// - Chip select held low whole transaction
// - Commit shift register when select rises
// - Serial clock at most quarter system clock
// - Extra ten percent margin on oscillator
// - Filter inputs against pulses under 20ns
// - Mode 3: idle high, falling drive
// - Oscillator mode: serial clock max 3.5MHz
// - External clock: serial clock max sixth
// - All registers zero after reset
// - Write address byte is address plus 0x80
// - Write one clears bit, zero keeps
// - Address byte plus four data bytes
// - Bit 39 high means write
// - Internal read once address bits arrive
// - Data always returned, ignored on writes
`timescale 1ns/1ps
module spi_cmd_device (
	// System clock domain
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	// Serial link
	spi_link_if.device link,
	// Driver enable pin and its filtered level
	input  wire logic  driver_enable_n,
	output logic       driver_enabled,
	// Hardware events into the write-one-to-clear register
	input  wire logic [31:0] status_set,
	// Register contents and commit strobe
	output logic [spi_cmd_pkg::REG_COUNT*32-1:0] reg_q,
	output logic                                 commit_pulse
);

	// ---------------------------------------------------------------
	// State types
	// ---------------------------------------------------------------
	typedef logic [spi_cmd_pkg::REG_COUNT-1:0][31:0] reg_arr_t;

	typedef struct packed {
		reg_arr_t regs;
		reg_arr_t view;
		logic     cs_prev;
		logic     commit;
	} sys_t;

	typedef struct packed {
		logic [spi_cmd_pkg::FRAME_BITS-1:0] shift;
		logic [spi_cmd_pkg::CNT_W-1:0]      cnt;
		logic [spi_cmd_pkg::ADDR_BITS-1:0]  prev_addr;
		logic [spi_cmd_pkg::DATA_BITS-1:0]  rd_word;
	} lnk_t;

	sys_t d_r;
	sys_t d_nxt;
	lnk_t l_r;
	lnk_t l_nxt;
	logic first_r;
	logic out_r;
	logic frame_clr;
	logic cs_filt;
	logic enable_n_filt;
	logic [spi_cmd_pkg::FRAME_BITS-1:0] cmd_word;
	logic [6:0]                         cmd_addr;
	logic [spi_cmd_pkg::REG_IDX_W-1:0]  cmd_idx;
	logic [spi_cmd_pkg::FRAME_BITS-1:0] rx_word;
	logic [6:0]                         rd_addr;
	logic [spi_cmd_pkg::FRAME_BITS-1:0] tx_word;
	logic [spi_cmd_pkg::CNT_W-1:0]      tx_idx;

	// ---------------------------------------------------------------
	// Input filters in the system domain
	// ---------------------------------------------------------------
	glitch_filter #(.INIT(1'b1)) u_cs_filt (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (link.chip_select_n),
		.filt_out (cs_filt)
	);

	glitch_filter #(.INIT(1'b1)) u_en_filt (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.async_in (driver_enable_n),
		.filt_out (enable_n_filt)
	);

	assign driver_enabled = ~enable_n_filt;

	// ---------------------------------------------------------------
	// Link domain: receive shift register and bit counter
	// ---------------------------------------------------------------

	// Frame start marker, preset by chip select high
	assign frame_clr = ~rst_n | link.chip_select_n;

	always_ff @(posedge link.sck or posedge frame_clr) begin
		if (frame_clr) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	// Shift on rising edge, latch read word after the address byte
	always_comb begin
		l_nxt   = l_r;
		rx_word = {l_r.shift[spi_cmd_pkg::FRAME_BITS-2:0],
			link.serial_in};
		rd_addr = rx_word[6:0];
		l_nxt.shift = rx_word;
		if (first_r) begin
			l_nxt.cnt = 6'h01;
		end else if (l_r.cnt != spi_cmd_pkg::CNT_MAX) begin
			l_nxt.cnt = l_r.cnt + 6'h01;
		end
		if (l_nxt.cnt == spi_cmd_pkg::CNT_ADDR_DONE) begin
			l_nxt.prev_addr = rx_word[spi_cmd_pkg::ADDR_BITS-1:0];
			// View is frozen while the frame runs
			if (rd_addr < 7'(spi_cmd_pkg::REG_COUNT)) begin
				l_nxt.rd_word =
					d_r.view[rd_addr[spi_cmd_pkg::REG_IDX_W-1:0]];
			end else begin
				l_nxt.rd_word = '0;
			end
		end
	end

	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: return data after each falling edge
	// ---------------------------------------------------------------
	assign tx_word = {l_r.prev_addr, l_r.rd_word};
	assign tx_idx  = 6'(spi_cmd_pkg::FRAME_BITS - 1) - l_r.cnt;

	always_ff @(negedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 1'b0;
		end else if (first_r) begin
			// Hold the top bit over the first rising edge
			out_r <= l_r.prev_addr[spi_cmd_pkg::ADDR_BITS-1];
		end else if (l_r.cnt < spi_cmd_pkg::CNT_FRAME) begin
			out_r <= tx_word[tx_idx];
		end else begin
			out_r <= 1'b0;
		end
	end

	// First bit is presented as soon as select falls
	assign link.serial_out    = first_r ?
		l_r.prev_addr[spi_cmd_pkg::ADDR_BITS-1] : out_r;
	assign link.serial_out_oe = ~link.chip_select_n;

	// ---------------------------------------------------------------
	// System domain: commit and register file
	// ---------------------------------------------------------------

	// Shift register is quiet once select is high again
	assign cmd_word = l_r.shift;
	assign cmd_addr = cmd_word[spi_cmd_pkg::ADDR_MSB:spi_cmd_pkg::ADDR_LSB];
	assign cmd_idx  = cmd_addr[spi_cmd_pkg::REG_IDX_W-1:0];

	always_comb begin
		d_nxt = d_r;
		if (ce) begin
			d_nxt.commit  = 1'b0;
			d_nxt.cs_prev = cs_filt;
			// Rising select with a full frame is a command
			if (cs_filt && !d_r.cs_prev &&
				l_r.cnt >= spi_cmd_pkg::CNT_FRAME) begin
				d_nxt.commit = 1'b1;
				if (cmd_word[spi_cmd_pkg::RW_POS] &&
					cmd_addr < 7'(spi_cmd_pkg::REG_COUNT)) begin
					if (cmd_addr == spi_cmd_pkg::WOC_ADDR) begin
						d_nxt.regs[cmd_idx] = d_r.regs[cmd_idx] &
							~cmd_word[spi_cmd_pkg::DATA_BITS-1:0];
					end else begin
						d_nxt.regs[cmd_idx] =
							cmd_word[spi_cmd_pkg::DATA_BITS-1:0];
					end
				end
			end
			// Hardware set wins over a clear in the same cycle
			d_nxt.regs[spi_cmd_pkg::WOC_ADDR[spi_cmd_pkg::REG_IDX_W-1:0]] =
				d_nxt.regs[spi_cmd_pkg::WOC_ADDR[
				spi_cmd_pkg::REG_IDX_W-1:0]] | status_set;
			// Read view follows registers only between frames
			if (cs_filt) begin
				d_nxt.view = d_r.regs;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_r.regs    <= {spi_cmd_pkg::REG_COUNT{
				spi_cmd_pkg::REG_RESET}};
			d_r.view    <= {spi_cmd_pkg::REG_COUNT{
				spi_cmd_pkg::REG_RESET}};
			d_r.cs_prev <= 1'b1;
			d_r.commit  <= 1'b0;
		end else begin
			d_r <= d_nxt;
		end
	end

	assign reg_q        = d_r.regs;
	assign commit_pulse = d_r.commit;

endmodule

/* rtl/spi_cmd_host.sv */
`timescale 1ns/1ps
module spi_cmd_host (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	// Serial link
	spi_link_if.host   link,
	// Clock speed selection
	input  wire logic  int_osc_mode,
	// Command request
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_write,
	input  wire logic [6:0]  cmd_addr,
	input  wire logic [31:0] cmd_wdata,
	// Response
	output logic             rsp_valid,
	output logic [7:0]       rsp_status,
	output logic [31:0]      rsp_data
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		H_IDLE,
		H_LEAD,
		H_LOW,
		H_HIGH,
		H_TRAIL,
		H_GAP
	} hst_state_t;

	typedef struct packed {
		hst_state_t                          state;
		logic [spi_cmd_pkg::HCNT_W-1:0]      cnt;
		logic [spi_cmd_pkg::CNT_W-1:0]       bits;
		logic [spi_cmd_pkg::FRAME_BITS-1:0]  tx;
		logic [spi_cmd_pkg::FRAME_BITS-1:0]  rx;
		logic                                sck;
		logic                                cs_n;
		logic                                mosi;
		logic                                rsp;
		logic                                s1;
		logic                                s2;
	} hst_t;

	hst_t h_r;
	hst_t h_nxt;
	logic [spi_cmd_pkg::HCNT_W-1:0]  half_m1;
	logic                            half_done;
	logic [spi_cmd_pkg::ADDR_BITS-1:0] addr_byte;

	// Half period of the serial clock
	assign half_m1 = int_osc_mode ?
		4'(spi_cmd_pkg::HALF_SLOW - 1) :
		4'(spi_cmd_pkg::HALF_FAST - 1);
	assign half_done = (h_r.cnt == half_m1);
	assign addr_byte = {1'b0, cmd_addr} |
		(cmd_write ? spi_cmd_pkg::WRITE_FLAG : 8'h00);

	// ---------------------------------------------------------------
	// Transaction sequencer
	// ---------------------------------------------------------------
	always_comb begin
		h_nxt = h_r;
		if (ce) begin
			h_nxt.s1  = link.serial_out_line;
			h_nxt.s2  = h_r.s1;
			h_nxt.rsp = 1'b0;
			h_nxt.cnt = h_r.cnt + 4'h1;
			unique case (h_r.state)
				H_IDLE: begin
					h_nxt.cnt = '0;
					if (cmd_valid) begin
						h_nxt.tx    = {addr_byte, cmd_wdata};
						h_nxt.mosi  = addr_byte[spi_cmd_pkg::ADDR_BITS-1];
						h_nxt.cs_n  = 1'b0;
						h_nxt.bits  = '0;
						h_nxt.state = H_LEAD;
					end
				end
				H_LEAD: begin
					if (half_done) begin
						h_nxt.cnt   = '0;
						h_nxt.sck   = 1'b0;
						h_nxt.state = H_LOW;
					end
				end
				H_LOW: begin
					if (half_done) begin
						h_nxt.cnt   = '0;
						h_nxt.sck   = 1'b1;
						h_nxt.rx    = {h_r.rx[spi_cmd_pkg::FRAME_BITS-2:0],
							h_r.s2};
						h_nxt.bits  = h_r.bits + 6'h01;
						h_nxt.state = H_HIGH;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						h_nxt.cnt = '0;
						if (h_r.bits == spi_cmd_pkg::CNT_FRAME) begin
							h_nxt.state = H_TRAIL;
						end else begin
							h_nxt.sck   = 1'b0;
							h_nxt.tx    = {h_r.tx[spi_cmd_pkg::FRAME_BITS-2:0],
								1'b0};
							h_nxt.mosi  =
								h_r.tx[spi_cmd_pkg::FRAME_BITS-2];
							h_nxt.state = H_LOW;
						end
					end
				end
				H_TRAIL: begin
					if (half_done) begin
						h_nxt.cnt   = '0;
						h_nxt.cs_n  = 1'b1;
						h_nxt.rsp   = 1'b1;
						h_nxt.state = H_GAP;
					end
				end
				H_GAP: begin
					if (h_r.cnt == 4'(spi_cmd_pkg::GAP_CYCLES - 1)) begin
						h_nxt.cnt   = '0;
						h_nxt.state = H_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			h_r       <= '0;
			h_r.state <= H_IDLE;
			h_r.sck   <= 1'b1;
			h_r.cs_n  <= 1'b1;
			h_r.s1    <= 1'b1;
			h_r.s2    <= 1'b1;
		end else begin
			h_r <= h_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign link.sck           = h_r.sck;
	assign link.chip_select_n = h_r.cs_n;
	assign link.serial_in     = h_r.mosi;
	assign cmd_ready          = ce && (h_r.state == H_IDLE);
	assign rsp_valid          = h_r.rsp;
	assign rsp_status         = h_r.rx[spi_cmd_pkg::FRAME_BITS-1:
		spi_cmd_pkg::DATA_BITS];
	assign rsp_data           = h_r.rx[spi_cmd_pkg::DATA_BITS-1:0];

endmodule

/* testbench/spi_link_assertions.sv */
`timescale 1ns/1ps
module spi_link_assertions (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link wires
	input wire logic sck,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [5:0] rise_cnt_r;
	logic       sck_q_r;

	// Count rising serial clocks inside one frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_cnt_r <= 6'h00;
			sck_q_r    <= 1'b1;
		end else begin
			sck_q_r <= sck;
			if (chip_select_n) begin
				rise_cnt_r <= 6'h00;
			end else if (sck && !sck_q_r) begin
				rise_cnt_r <= rise_cnt_r + 6'h01;
			end
		end
	end

	chk_oe_follows_sel: assert property (
		serial_out_oe == !chip_select_n
	) else $error("output enable not tied to select");
	chk_sck_idle_high: assert property (
		chip_select_n |-> sck
	) else $error("serial clock low outside frame");
	chk_si_after_fall: assert property (
		(!chip_select_n && $past(!chip_select_n) && $changed(serial_in))
		|-> !sck
	) else $error("serial input moved while clock high");
	chk_so_after_fall: assert property (
		(!chip_select_n && $past(!chip_select_n) && $changed(serial_out))
		|-> !sck
	) else $error("serial output moved while clock high");
	chk_sck_low_min: assert property (
		$fell(sck) |=> !sck [*2]
	) else $error("serial clock low phase too short");
	chk_sck_high_min: assert property (
		($rose(sck) && !chip_select_n) |=> sck [*2]
	) else $error("serial clock high phase too short");
	chk_frame_len: assert property (
		$rose(chip_select_n) |-> rise_cnt_r == 6'h28
	) else $error("frame not forty clocks");
	chk_sel_holds: assert property (
		$fell(chip_select_n) |=> !chip_select_n [*8]
	) else $error("select dropped early in frame");
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic         clk;
	logic         rst_n;
	logic         int_osc_mode;
	logic         cmd_valid;
	logic         cmd_ready;
	logic         cmd_write;
	logic [6:0]   cmd_addr;
	logic [31:0]  cmd_wdata;
	logic         rsp_valid;
	logic [7:0]   rsp_status;
	logic [31:0]  rsp_data;
	logic         driver_enable_n;
	logic         driver_enabled;
	logic [31:0]  status_set;
	logic [255:0] reg_q;
	logic [255:0] reg_q2;
	logic         commit_pulse;
	logic         commit2;
	logic [39:0]  wire_sh;
	logic [31:0]  exp_reg [8];
	logic [7:0]   prev_ab;
	int           err_total;
	int           num_checks;
	int           cyc;
	int           commits2;
	int           commits;

	spi_link_if link_w ();
	spi_link_if link_f ();

	spi_cmd_host spi_cmd_host_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.link(link_w.host), .int_osc_mode(int_osc_mode),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .rsp_data(rsp_data));
	spi_cmd_device spi_cmd_device_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.link(link_w.device), .driver_enable_n(driver_enable_n),
		.driver_enabled(driver_enabled), .status_set(status_set),
		.reg_q(reg_q), .commit_pulse(commit_pulse));
	// Second device end, driven by the bench with short, full and long frames
	spi_cmd_device spi_cmd_device_f (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.link(link_f.device), .driver_enable_n(1'b1),
		.driver_enabled(), .status_set(32'h00000000),
		.reg_q(reg_q2), .commit_pulse(commit2));
	spi_link_assertions spi_link_assertions_i (.clk(clk), .rst_n(rst_n),
		.sck(link_w.sck), .chip_select_n(link_w.chip_select_n),
		.serial_in(link_w.serial_in), .serial_out(link_w.serial_out),
		.serial_out_oe(link_w.serial_out_oe));

	// System clock
	always #12.5 clk = ~clk;

	// Bits the host puts on the wire
	always @(posedge link_w.sck) begin
		if (!link_w.chip_select_n) begin
			wire_sh <= {wire_sh[38:0], link_w.serial_in};
		end
	end

	// Commit counts of both ends and hang guard
	always @(posedge clk) begin
		cyc++;
		if (commit2 === 1'b1) begin
			commits2++;
		end
		if (commit_pulse === 1'b1) begin
			commits++;
		end
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp,
		input string msg);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check_regs();
		for (int i = 0; i < 8; i++) begin
			check(reg_q[32*i +: 32], exp_reg[i], "register");
		end
	endtask

	task automatic do_cmd(input logic w, input logic [6:0] a,
		input logic [31:0] d);
		int n;
		int c;
		n = 0;
		c = commits;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#2;
			n++;
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr  = a;
		cmd_wdata = d;
		@(posedge clk);
		#2;
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 700) begin
			@(posedge clk);
			#2;
			n++;
		end
		check(rsp_valid, 1'b1, "no response");
		check(n, (int_osc_mode ? spi_cmd_pkg::HALF_SLOW :
			spi_cmd_pkg::HALF_FAST) * (2 * spi_cmd_pkg::FRAME_BITS + 2),
			"frame length");
		check(rsp_status, prev_ab, "status byte");
		check(wire_sh >> (w ? 0 : 32), {w, a, d} >> (w ? 0 : 32), "frame");
		check({link_w.sck, link_w.chip_select_n, link_w.serial_out_line},
			3'h7, "idle");
		prev_ab = {w, a};
		repeat (10) @(posedge clk);
		#2;
		check(commits - c, 1, "commit count");
	endtask

	task automatic send_frame(input logic [47:0] f, input int n);
		link_f.chip_select_n = 1'b0;
		#100;
		for (int k = n - 1; k >= 0; k--) begin
			link_f.sck       = 1'b0;
			link_f.serial_in = f[k];
			#75;
			link_f.sck = 1'b1;
			#75;
		end
		#100;
		link_f.chip_select_n = 1'b1;
		link_f.serial_in     = ~link_f.serial_in;
		#400;
	endtask

	task automatic sc_reset();
		check_regs();
		check(driver_enabled, 1'b0, "enable at reset");
	endtask

	task automatic sc_write_all();
		for (int i = 0; i < 8; i++) begin
			if (i != 1) begin
				exp_reg[i] = 32'h9ab000c1 + 32'h01010101 * i;
				do_cmd(1'b1, i[6:0], exp_reg[i]);
				check_regs();
			end
		end
		do_cmd(1'b1, 7'h12, 32'hffffffff);
		check_regs();
	endtask

	task automatic sc_clear_on_write();
		status_set = 32'h000000ff;
		repeat (2) @(posedge clk);
		#2;
		status_set = 32'h00000000;
		repeat (3) @(posedge clk);
		#2;
		exp_reg[1] = 32'h000000ff;
		check_regs();
		do_cmd(1'b1, 7'h01, 32'h0000000f);
		exp_reg[1] = 32'h000000f0;
		check_regs();
	endtask

	task automatic sc_read_all();
		for (int i = 0; i < 9; i++) begin
			do_cmd(1'b0, (i == 8) ? 7'h10 : i[6:0], 32'h00000000);
			check(rsp_data, (i == 8) ? 32'h0 : exp_reg[i], "read");
		end
		check_regs();
		int_osc_mode = 1'b1;
		do_cmd(1'b0, 7'h03, 32'h00000000);
		check(rsp_data, exp_reg[3], "slow read");
		int_osc_mode = 1'b0;
	endtask

	task automatic sc_filter();
		#18;
		driver_enable_n = 1'b0;
		#10;
		driver_enable_n = 1'b1;
		repeat (4) @(posedge clk);
		#2;
		check(driver_enabled, 1'b0, "glitch passed");
		driver_enable_n = 1'b0;
		repeat (5) @(posedge clk);
		#2;
		check(driver_enabled, 1'b1, "enable lost");
		driver_enable_n = 1'b1;
	endtask

	task automatic sc_bad_frames();
		send_frame(48'h000000858001, 16);
		check(commits2, 0, "short frame");
		check(reg_q2[32*5 +: 32], 32'h0, "short frame reg");
		send_frame(48'h0000_85c0de0001, 40);
		send_frame(48'h0086_11112222, 48);
		check(commits2, 2, "commits");
		check(reg_q2[32*5 +: 32], 32'hc0de0001, "full frame");
		check(reg_q2[32*6 +: 32], 32'h11112222, "long frame");
	endtask

	// Main sequence
	initial begin
		clk                  = 1'b0;
		rst_n                = 1'b0;
		int_osc_mode         = 1'b0;
		cmd_valid            = 1'b0;
		cmd_write            = 1'b0;
		cmd_addr             = 7'h00;
		cmd_wdata            = 32'h00000000;
		driver_enable_n      = 1'b1;
		status_set           = 32'h00000000;
		link_f.sck           = 1'b1;
		link_f.chip_select_n = 1'b1;
		link_f.serial_in     = 1'b0;
		prev_ab              = 8'h00;
		for (int i = 0; i < 8; i++) begin
			exp_reg[i] = 32'h00000000;
		end
		repeat (3) @(posedge clk);
		#2;
		rst_n = 1'b1;
		sc_reset();
		sc_write_all();
		sc_clear_on_write();
		sc_read_all();
		sc_filter();
		sc_bad_frames();
		end_sim();
	end
endmodule
